// >>> binary_packet_system_handler.sv
// Function
// - answer with packet 0, four bytes, byte 0 the answered identifier
// - bytes 1 and 2 carry answered packet's crc, little endian
// - byte 3 is the result code, 0 means accepted and applied
// - code 1 for payload crc error, code 2 for wrong length
// - code 3 out of range, 4 storage failure, 5 system not ready
// - code 6 for an unrecognised identifier
// - request packet is id 1, one requested identifier per payload byte
// - boot mode is id 2, one byte, read/write; 0 loader, 1 main
// - ids 20 to 43 are output-only with fixed lengths, except 31 which is variable
// - ids 44 to 48 read/write, lengths 60 36 24 16 8
// - ids 55 56 67 68 input-only; 55 variable, then 8 13 25
// - ids 31 55 181 187 have no fixed length check
// - config ids 180 182 184 185 186 188 read/write, fixed lengths
// - 190 and 193 write-only, 191 read-only, 189 and 194 read/write
// - ids 195 198 199 read/write with lengths 33 64 65
// - ids 49-54 57 58 72 73 fixed; 52 53 57 72 writable
// - header gives identifier, length and 16-bit payload crc
// - payload crc is ccitt seeded all ones over payload only
// - configuration writes get an acknowledgement of the outcome
// - a requested identifier that is not readable is answered with code 6
`default_nettype none

module binary_packet_system_handler
  import binpkt_pkg::*;
(
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  // received header from the framing layer
  input wire logic I_RX_HDR,
  input wire binpkt_pkg::byte_t I_RX_ID,
  input wire binpkt_pkg::byte_t I_RX_LEN,
  input wire binpkt_pkg::crc_t I_RX_CRC,
  // received payload bytes
  input wire logic I_RX_VALID,
  input wire binpkt_pkg::byte_t I_RX_DATA,
  output logic O_RX_READY,
  // system condition
  input wire logic I_SYS_READY,
  input wire logic I_NVM_FAIL,
  input wire logic I_RANGE_ERR,
  // outgoing packet stream to the framing layer
  output logic O_TX_VALID,
  output logic O_TX_SOP,
  output logic [7:0] O_TX_ID,
  output logic [7:0] O_TX_LEN,
  output logic [7:0] O_TX_DATA,
  input wire logic I_TX_READY,
  // requests for packets produced elsewhere
  output logic O_REQ_VALID,
  output logic [7:0] O_REQ_ID,
  input wire logic I_REQ_READY,
  // accepted writes
  output logic O_APPLY_VALID,
  output logic [7:0] O_APPLY_ID,
  output logic [7:0] O_BOOT_MODE
);

  // ------------------------------------------------------------
  // packet table
  // ------------------------------------------------------------

  // attributes and fixed length per identifier
  function automatic tbl_t tbl_lookup(input byte_t id);
    case (id)
      8'h00: return {ATT_RO, 8'h04};
      8'h01: return {ATT_WO_VAR, 8'h00};
      8'h02: return {ATT_RW, 8'h01};
      8'h03: return {ATT_RO, 8'h18};
      8'h04: return {ATT_WO, 8'h04};
      8'h05: return {ATT_WO, 8'h04};
      8'h0A: return {ATT_RW_VAR, 8'h00};
      8'h14: return {ATT_RO, 8'h64};
      8'h15: return {ATT_RO, 8'h08};
      8'h16: return {ATT_RO, 8'h0E};
      8'h17: return {ATT_RO, 8'h04};
      8'h18, 8'h19, 8'h1A: return {ATT_RO, 8'h0C};
      8'h1B: return {ATT_RO, 8'h10};
      8'h1C: return {ATT_RO, 8'h30};
      8'h1D: return {ATT_RO, 8'h4A};
      8'h1E: return {ATT_RO, 8'h0D};
      8'h1F: return {ATT_RO_VAR, 8'h00};
      8'h20, 8'h21: return {ATT_RO, 8'h18};
      8'h22: return {ATT_RO, 8'h1A};
      8'h23, 8'h24, 8'h25: return {ATT_RO, 8'h0C};
      8'h26: return {ATT_RO, 8'h10};
      8'h27: return {ATT_RO, 8'h0C};
      8'h28: return {ATT_RO, 8'h10};
      8'h29: return {ATT_RO, 8'h24};
      8'h2A, 8'h2B: return {ATT_RO, 8'h0C};
      8'h2C: return {ATT_RW, 8'h3C};
      8'h2D: return {ATT_RW, 8'h24};
      8'h2E: return {ATT_RW, 8'h18};
      8'h2F: return {ATT_RW, 8'h10};
      8'h30: return {ATT_RW, 8'h08};
      8'h31: return {ATT_RO, 8'h08};
      8'h32: return {ATT_RO, 8'h0C};
      8'h33: return {ATT_RO, 8'h14};
      8'h34, 8'h35: return {ATT_RW, 8'h08};
      8'h36: return {ATT_RO, 8'h04};
      8'h37: return {ATT_WO_VAR, 8'h00};
      8'h38: return {ATT_WO, 8'h08};
      8'h39: return {ATT_RW, 8'h0C};
      8'h3A: return {ATT_RO, 8'h10};
      8'h43: return {ATT_WO, 8'h0D};
      8'h44: return {ATT_WO, 8'h19};
      8'h48: return {ATT_RW, 8'h08};
      8'h49: return {ATT_RO, 8'h18};
      8'hB4: return {ATT_RW, 8'h04};
      8'hB5: return {ATT_RW_VAR, 8'h00};
      8'hB6: return {ATT_RW, 8'h11};
      8'hB8: return {ATT_RW, 8'h04};
      8'hB9: return {ATT_RW, 8'h49};
      8'hBA: return {ATT_RW, 8'h11};
      8'hBB: return {ATT_RW_VAR, 8'h00};
      8'hBC: return {ATT_RW, 8'h0D};
      8'hBD: return {ATT_RW, 8'h31};
      8'hBE: return {ATT_WO, 8'h01};
      8'hBF: return {ATT_RO, 8'h03};
      8'hC0: return {ATT_RW, 8'h08};
      8'hC1: return {ATT_WO, 8'h05};
      8'hC2: return {ATT_RW, 8'h31};
      8'hC3: return {ATT_RW, 8'h21};
      8'hC6: return {ATT_RW, 8'h40};
      8'hC7: return {ATT_RW, 8'h41};
      default: return {ATT_NONE, 8'h00};
    endcase
  endfunction : tbl_lookup

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  state_e state_q, state_d, ret_q;
  logic rx_ready_q;
  byte_t id_q, len_q, tlen_q, cnt_q, boot_val_q, boot_q, idx_q, rid, res;
  crc_t hdr_crc_q, crc_q, crc_next;
  logic [3:0] attr_q;
  tbl_t hdr_ent, rid_ent;
  byte_t req_mem [0:255];
  logic tx_valid_q, tx_sop_q;
  byte_t tx_id_q, tx_len_q;
  logic [31:0] tx_sh_q;
  logic [2:0] tx_rem_q;
  logic req_valid_q, apply_valid_q;
  byte_t req_id_q, apply_id_q, ack_id, ack_code;
  logic hdr_take, byte_take, last_byte, tx_hs, tx_done, req_hs, req_end;
  logic is_req_ok, ack_load, boot_load, fwd_load, req_ack_load;

  // ------------------------------------------------------------
  // strobes
  // ------------------------------------------------------------

  // handshakes and per-state actions
  assign hdr_take = (state_q == ST_IDLE) && rx_ready_q && I_RX_HDR;
  assign byte_take = (state_q == ST_RXPAY) && rx_ready_q && I_RX_VALID;
  assign last_byte = byte_take && (cnt_q == len_q - 8'h01);
  assign tx_hs = tx_valid_q && I_TX_READY;
  assign tx_done = tx_hs && (tx_rem_q == 3'h1);
  assign req_hs = req_valid_q && I_REQ_READY;
  assign req_end = (state_q == ST_REQ) && (idx_q == len_q);
  assign rid = req_mem[idx_q];
  assign hdr_ent = tbl_lookup(I_RX_ID);
  assign rid_ent = tbl_lookup(rid);
  assign is_req_ok = (id_q == ID_REQ) && (res == RES_OK);
  assign boot_load = (state_q == ST_REQ) && !req_end && (rid == ID_BOOT);
  assign fwd_load = (state_q == ST_REQ) && !req_end && (rid != ID_BOOT) && rid_ent[ATTR_RD];
  assign req_ack_load = (state_q == ST_REQ) && !req_end && (rid != ID_BOOT) && !rid_ent[ATTR_RD];
  assign ack_load = ((state_q == ST_CHECK) && !is_req_ok) || req_ack_load;

  // result code of the packet just received, first failure wins
  always_comb
  begin
    res = RES_OK;
    if (!attr_q[3] || !attr_q[1])
      res = RES_UNKNOWN;
    else if (!attr_q[0] && (len_q != tlen_q))
      res = RES_SIZE;
    else if (crc_q != hdr_crc_q)
      res = RES_CRC;
    else if (!I_SYS_READY)
      res = RES_NOT_READY;
    else if (I_RANGE_ERR || ((id_q == ID_BOOT) && (boot_val_q > BOOT_MAIN)))
      res = RES_RANGE;
    else if ((id_q >= ID_CFG_FIRST) && I_NVM_FAIL)
      res = RES_FLASH;
  end

  // answered identifier and code
  assign ack_id = (state_q == ST_CHECK) ? id_q : rid;
  assign ack_code = (state_q == ST_CHECK) ? res : RES_UNKNOWN;

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------

  // next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
        if (hdr_take)
          state_d = (I_RX_LEN == 8'h00) ? ST_CHECK : ST_RXPAY;
      ST_RXPAY:
        if (last_byte)
          state_d = ST_CHECK;
      ST_CHECK:
        state_d = is_req_ok ? ST_REQ : ST_TX;
      ST_TX:
        if (tx_done)
          state_d = ret_q;
      ST_REQ:
        if (req_end)
          state_d = ST_IDLE;
        else if (fwd_load)
          state_d = ST_FWD;
        else
          state_d = ST_TX;
      ST_FWD:
        if (req_hs)
          state_d = ST_REQ;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // state, return point and receive ready
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      state_q <= ST_IDLE;
      ret_q <= ST_IDLE;
      rx_ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      rx_ready_q <= (state_d == ST_IDLE) || (state_d == ST_RXPAY);
      if (ack_load || boot_load)
        ret_q <= (state_q == ST_REQ) ? ST_REQ : ST_IDLE;
    end
  end

  // ------------------------------------------------------------
  // receive
  // ------------------------------------------------------------

  // header capture and payload count
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      id_q <= 8'h00;
      len_q <= 8'h00;
      hdr_crc_q <= 16'h0000;
      attr_q <= ATT_NONE;
      tlen_q <= 8'h00;
      cnt_q <= 8'h00;
    end
    else if (hdr_take)
    begin
      id_q <= I_RX_ID;
      len_q <= I_RX_LEN;
      hdr_crc_q <= I_RX_CRC;
      attr_q <= hdr_ent[11:8];
      tlen_q <= hdr_ent[7:0];
      cnt_q <= 8'h00;
    end
    else if (byte_take)
      cnt_q <= cnt_q + 8'h01;
  end

  // payload crc, header not included
  crc16_ccitt_step u_crc (
    .i_crc(crc_q),
    .i_data(I_RX_DATA),
    .o_crc(crc_next)
  );

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
      crc_q <= CRC_SEED;
    else if (hdr_take)
      crc_q <= CRC_SEED;
    else if (byte_take)
      crc_q <= crc_next;
  end

  // boot mode candidate byte
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
      boot_val_q <= BOOT_RESET;
    else if (byte_take && (id_q == ID_BOOT) && (cnt_q == 8'h00))
      boot_val_q <= I_RX_DATA;
  end

  // requested identifiers in arrival order
  always_ff @(posedge I_MCLK)
  begin
    if (byte_take && (id_q == ID_REQ))
      req_mem[cnt_q] <= I_RX_DATA;
  end

  // ------------------------------------------------------------
  // transmit
  // ------------------------------------------------------------

  // acknowledge and boot mode packets, byte 0 first
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      tx_valid_q <= 1'b0;
      tx_sop_q <= 1'b0;
      tx_id_q <= 8'h00;
      tx_len_q <= 8'h00;
      tx_sh_q <= 32'h0000_0000;
      tx_rem_q <= 3'h0;
    end
    else if (ack_load)
    begin
      tx_valid_q <= 1'b1;
      tx_sop_q <= 1'b1;
      tx_id_q <= ID_ACK;
      tx_len_q <= ACK_LEN;
      tx_sh_q <= {ack_code, hdr_crc_q[15:8], hdr_crc_q[7:0], ack_id};
      tx_rem_q <= ACK_LEN[2:0];
    end
    else if (boot_load)
    begin
      tx_valid_q <= 1'b1;
      tx_sop_q <= 1'b1;
      tx_id_q <= ID_BOOT;
      tx_len_q <= BOOT_LEN;
      tx_sh_q <= {24'h00_0000, boot_q};
      tx_rem_q <= BOOT_LEN[2:0];
    end
    else if (tx_hs)
    begin
      tx_sop_q <= 1'b0;
      tx_sh_q <= {8'h00, tx_sh_q[31:8]};
      tx_rem_q <= tx_rem_q - 3'h1;
      if (tx_rem_q == 3'h1)
        tx_valid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // request service
  // ------------------------------------------------------------

  // walk the request list in order, hand readable ids other than boot mode outward
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      idx_q <= 8'h00;
      req_valid_q <= 1'b0;
      req_id_q <= 8'h00;
    end
    else
    begin
      if (state_q == ST_CHECK)
        idx_q <= 8'h00;
      else if (boot_load || fwd_load || req_ack_load)
        idx_q <= idx_q + 8'h01;
      if (fwd_load)
      begin
        req_valid_q <= 1'b1;
        req_id_q <= rid;
      end
      else if (req_hs)
        req_valid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // apply accepted writes
  // ------------------------------------------------------------

  // boot mode is kept here, others are announced
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      boot_q <= BOOT_RESET;
      apply_valid_q <= 1'b0;
      apply_id_q <= 8'h00;
    end
    else
    begin
      apply_valid_q <= (state_q == ST_CHECK) && (res == RES_OK) && (id_q != ID_REQ) && (id_q != ID_BOOT);
      if (state_q == ST_CHECK)
        apply_id_q <= id_q;
      if ((state_q == ST_CHECK) && (res == RES_OK) && (id_q == ID_BOOT))
        boot_q <= boot_val_q;
    end
  end

  // outputs straight from flops
  assign O_RX_READY = rx_ready_q;
  assign O_TX_VALID = tx_valid_q;
  assign O_TX_SOP = tx_sop_q;
  assign O_TX_ID = tx_id_q;
  assign O_TX_LEN = tx_len_q;
  assign O_TX_DATA = tx_sh_q[7:0];
  assign O_REQ_VALID = req_valid_q;
  assign O_REQ_ID = req_id_q;
  assign O_APPLY_VALID = apply_valid_q;
  assign O_APPLY_ID = apply_id_q;
  assign O_BOOT_MODE = boot_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);

  logic chk_acked, chk_fixed_ok;
  assign chk_acked = (state_q == ST_CHECK) && (id_q != ID_REQ);
  assign chk_fixed_ok = attr_q[3] && attr_q[1] && (attr_q[0] || (len_q == tlen_q));

  sequence s_ack_load;
    ack_load;
  endsequence

  sequence s_ack_out;
    O_TX_VALID && O_TX_SOP && (O_TX_ID == ID_ACK) && (O_TX_LEN == ACK_LEN);
  endsequence

  ack_header_a: assert property (s_ack_load |=> s_ack_out)
    else $error("ack header wrong");
  ack_first_a: assert property (chk_acked |=> (O_TX_DATA == $past(id_q)))
    else $error("ack byte 0 not the answered id");
  ack_crc_a: assert property (s_ack_load |=> (tx_sh_q[23:8] == $past(hdr_crc_q)))
    else $error("ack crc bytes wrong");
  boot_ok_a: assert property (chk_acked && (id_q == ID_BOOT) && chk_fixed_ok && (crc_q == hdr_crc_q)
    && I_SYS_READY && !I_RANGE_ERR && (boot_val_q <= BOOT_MAIN)
    |=> (tx_sh_q[31:24] == RES_OK) && (O_BOOT_MODE == $past(boot_val_q)))
    else $error("good boot write not accepted");
  crc_code_a: assert property (chk_acked && chk_fixed_ok && (crc_q != hdr_crc_q)
    |=> (tx_sh_q[31:24] == RES_CRC))
    else $error("crc error not reported");
  size_code_a: assert property (chk_acked && attr_q[3] && attr_q[1] && !attr_q[0] && (len_q != tlen_q)
    |=> (tx_sh_q[31:24] == RES_SIZE))
    else $error("length error not reported");
  not_ready_a: assert property (chk_acked && chk_fixed_ok && (crc_q == hdr_crc_q) && !I_SYS_READY
    |=> (tx_sh_q[31:24] == RES_NOT_READY))
    else $error("not ready not reported");
  unknown_id_a: assert property (chk_acked && !attr_q[3] |=> (tx_sh_q[31:24] == RES_UNKNOWN))
    else $error("unknown id not reported");
  var_length_a: assert property ((state_q == ST_CHECK) && attr_q[0] |-> (res != RES_SIZE))
    else $error("variable length packet rejected for size");
  req_order_a: assert property (fwd_load |=> O_REQ_VALID && (O_REQ_ID == $past(rid))
    && (idx_q == $past(idx_q) + 8'h01))
    else $error("request not forwarded in order");

endmodule : binary_packet_system_handler

`default_nettype wire

// >>> binpkt_pkg.sv
`default_nettype none

package binpkt_pkg;

  // ------------------------------------------------------------
  // basic types
  // ------------------------------------------------------------
  typedef logic [7:0] byte_t;
  typedef logic [15:0] crc_t;
  typedef logic [11:0] tbl_t;

  // handler states
  typedef enum logic [2:0] {ST_IDLE, ST_RXPAY, ST_CHECK, ST_TX, ST_REQ, ST_FWD} state_e;

  // ------------------------------------------------------------
  // payload check
  // ------------------------------------------------------------
  localparam crc_t CRC_SEED = 16'hFFFF;
  localparam crc_t CRC_POLY = 16'h1021;

  // ------------------------------------------------------------
  // system packet identifiers and lengths
  // ------------------------------------------------------------
  localparam byte_t ID_ACK = 8'h00;
  localparam byte_t ID_REQ = 8'h01;
  localparam byte_t ID_BOOT = 8'h02;
  localparam byte_t ID_CFG_FIRST = 8'hB4;
  localparam byte_t ACK_LEN = 8'h04;
  localparam byte_t BOOT_LEN = 8'h01;

  // boot mode values
  localparam byte_t BOOT_LOADER = 8'h00;
  localparam byte_t BOOT_MAIN = 8'h01;
  localparam byte_t BOOT_RESET = BOOT_MAIN;

  // ------------------------------------------------------------
  // acknowledge result codes
  // ------------------------------------------------------------
  localparam byte_t RES_OK = 8'h00;
  localparam byte_t RES_CRC = 8'h01;
  localparam byte_t RES_SIZE = 8'h02;
  localparam byte_t RES_RANGE = 8'h03;
  localparam byte_t RES_FLASH = 8'h04;
  localparam byte_t RES_NOT_READY = 8'h05;
  localparam byte_t RES_UNKNOWN = 8'h06;

  // ------------------------------------------------------------
  // packet table entry: attribute nibble above the length byte
  // ------------------------------------------------------------
  localparam int ATTR_KNOWN = 11;
  localparam int ATTR_RD = 10;
  localparam int ATTR_WR = 9;
  localparam int ATTR_VAR = 8;
  localparam logic [3:0] ATT_NONE = 4'h0;
  localparam logic [3:0] ATT_RO = 4'hC;
  localparam logic [3:0] ATT_WO = 4'hA;
  localparam logic [3:0] ATT_RW = 4'hE;
  localparam logic [3:0] ATT_RO_VAR = 4'hD;
  localparam logic [3:0] ATT_WO_VAR = 4'hB;
  localparam logic [3:0] ATT_RW_VAR = 4'hF;

endpackage : binpkt_pkg

`default_nettype wire

// >>> crc16_ccitt_step.sv
`default_nettype none

module crc16_ccitt_step
  import binpkt_pkg::*;
(
  // running value and next payload byte
  input wire binpkt_pkg::crc_t i_crc,
  input wire binpkt_pkg::byte_t i_data,
  // value after the byte
  output logic [15:0] o_crc
);

  logic [15:0] c;

  // msb-first shift of one byte through the polynomial
  always_comb
  begin
    c = i_crc ^ {i_data, 8'h00};
    for (int b = 0; b < 8; b++)
    begin
      c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
    end
    o_crc = c;
  end

endmodule : crc16_ccitt_step

`default_nettype wire

// >>> host_model.sv
`default_nettype none

module host_model
  import binpkt_pkg::*;
(
  // clock and stall choice
  input wire logic i_clk,
  input wire logic i_stall,
  // packet side of the handler
  input wire logic i_rx_ready,
  output logic o_hdr,
  output binpkt_pkg::byte_t o_id,
  output binpkt_pkg::byte_t o_len,
  output binpkt_pkg::crc_t o_crc,
  output logic o_valid,
  output binpkt_pkg::byte_t o_data,
  // sinks for answers and requests
  output logic o_tx_ready,
  output logic o_req_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_hdr = 1'b0;
    o_valid = 1'b0;
    {o_id, o_len, o_crc, o_data} = '0;
  end

  // sinks stall with the bench's random choice
  always @(posedge i_clk)
  begin
    #1;
    o_tx_ready = ~i_stall;
    o_req_ready = ~i_stall;
  end

  // hold a unit until an edge with ready high takes it
  task automatic hold;
    while (i_rx_ready !== 1'b1)
      @(posedge i_clk) #1;
    @(posedge i_clk);
    #1;
  endtask : hold

  // header, then payload one byte a cycle; released lines show garbage
  task automatic send(input byte_t id, input byte_t pl[$], input crc_t crc);
    o_hdr = 1'b1;
    o_id = id;
    o_len = byte_t'(pl.size());
    o_crc = crc;
    hold();
    o_hdr = 1'b0;
    o_id = ~o_id;
    o_len = ~o_len;
    o_crc = ~o_crc;
    foreach (pl[i])
    begin
      o_valid = 1'b1;
      o_data = pl[i];
      hold();
    end
    o_valid = 1'b0;
    o_data = ~o_data;
  endtask : send
endmodule : host_model

`default_nettype wire

// >>> tb_top.sv
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import binpkt_pkg::*;

  logic clk, rst_n, stall, sys_rdy, nvm, rng, hdr, rvalid, rx_ready;
  logic tx_valid, tx_sop, tx_ready, req_valid, req_ready, apply_valid;
  logic [7:0] tx_id, tx_len, tx_data, req_id, apply_id, boot;
  byte_t id, len, rdata, pl[$], lfsr, app_q[$];
  crc_t crc, rcrc;
  logic [24:0] exp_q[$], req_q[$], ex;
  int errors, cmp_count, cyc;

  // ------------------------------------------------------------
  // clock, partner and design
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  host_model u_host (.i_clk(clk), .i_stall(stall), .i_rx_ready(rx_ready), .o_hdr(hdr), .o_id(id),
    .o_len(len), .o_crc(crc), .o_valid(rvalid), .o_data(rdata), .o_tx_ready(tx_ready), .o_req_ready(req_ready));

  binary_packet_system_handler dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_RX_HDR(hdr), .I_RX_ID(id),
    .I_RX_LEN(len), .I_RX_CRC(crc), .I_RX_VALID(rvalid), .I_RX_DATA(rdata), .O_RX_READY(rx_ready),
    .I_SYS_READY(sys_rdy), .I_NVM_FAIL(nvm), .I_RANGE_ERR(rng), .O_TX_VALID(tx_valid), .O_TX_SOP(tx_sop),
    .O_TX_ID(tx_id), .O_TX_LEN(tx_len), .O_TX_DATA(tx_data), .I_TX_READY(tx_ready), .O_REQ_VALID(req_valid),
    .O_REQ_ID(req_id), .I_REQ_READY(req_ready), .O_APPLY_VALID(apply_valid), .O_APPLY_ID(apply_id),
    .O_BOOT_MODE(boot));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic byte_t rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd

  // payload check value, seeded all ones
  function automatic crc_t crc_of(input byte_t p[$]);
    crc_t c;
    c = 16'hFFFF;
    foreach (p[i])
    begin
      c = c ^ {p[i], 8'h00};
      repeat (8) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
    end
    return c;
  endfunction : crc_of

  task automatic chk(input logic [24:0] got, input logic [24:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic fill(input int n);
    pl.delete();
    repeat (n) pl.push_back(rnd());
  endtask : fill

  // note the acknowledge bytes with start flag: answered id, crc low, crc high, code
  task automatic note_ack(input byte_t aid, input crc_t c, input byte_t code);
    exp_q.push_back({1'b1, ID_ACK, ACK_LEN, aid});
    exp_q.push_back({1'b0, ID_ACK, ACK_LEN, c[7:0]});
    exp_q.push_back({1'b0, ID_ACK, ACK_LEN, c[15:8]});
    exp_q.push_back({1'b0, ID_ACK, ACK_LEN, code});
  endtask : note_ack

  task automatic wait_idle(input string name);
    for (int k = 0; k < 2000 && !(exp_q.size() == 0 && req_q.size() == 0 && app_q.size() == 0
      && rx_ready === 1'b1); k++)
      @(posedge clk) #1;
    if (exp_q.size() != 0 || req_q.size() != 0 || app_q.size() != 0)
      chk(25'h0, 25'h1, "answers missing");
    $display("test %s done", name);
  endtask : wait_idle

  // write a packet, optionally with a broken crc field, and expect the code
  task automatic run(input byte_t pid, input logic bad, input byte_t code);
    crc_t c;
    c = crc_of(pl) ^ {15'h0, bad};
    note_ack(pid, c, code);
    if (code == RES_OK && pid != ID_BOOT)
      app_q.push_back(pid);
    u_host.send(pid, pl, c);
    wait_idle($sformatf("write %0d", pid));
  endtask : run

  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------
  // watchers: every taken byte or request meets the oldest note
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      ex = (exp_q.size() != 0) ? exp_q.pop_front() : {25{1'bx}};
      chk({tx_sop, tx_id, tx_len, tx_data}, ex, "tx byte");
    end
    if (req_valid === 1'b1 && req_ready === 1'b1)
    begin
      ex = (req_q.size() != 0) ? req_q.pop_front() : {25{1'bx}};
      chk({17'h0, req_id}, ex, "request id");
    end
    if (apply_valid === 1'b1)
    begin
      ex = (app_q.size() != 0) ? {17'h0, app_q.pop_front()} : {25{1'bx}};
      chk({17'h0, apply_id}, ex, "applied id");
    end
  end

  // cycle ceiling, counted as a mismatch
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      give_verdict();
    end
  end

  // random stalls of the far side
  always @(posedge clk)
    stall <= #1 rnd() > 8'hA0;

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  byte_t wid[12] = '{44, 45, 46, 47, 48, 56, 68, 182, 185, 199, 190, 193};
  int wlen[12] = '{60, 36, 24, 16, 8, 8, 25, 17, 73, 65, 1, 5};

  initial
  begin
    {errors, cmp_count, cyc} = '0;
    lfsr = 8'h11;
    {rst_n, stall, nvm, rng} = '0;
    sys_rdy = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({17'h0, boot}, {17'h0, BOOT_MAIN}, "boot reset");
    pl = '{8'h00};
    run(ID_BOOT, 1'b0, RES_OK);
    chk({17'h0, boot}, {17'h0, BOOT_LOADER}, "boot mode");
    pl = '{8'h01};
    run(ID_BOOT, 1'b1, RES_CRC);
    pl = '{8'h05};
    run(ID_BOOT, 1'b0, RES_RANGE);
    chk({17'h0, boot}, {17'h0, BOOT_LOADER}, "boot kept");
    fill(7);
    run(8'd48, 1'b0, RES_SIZE);
    foreach (wid[i])
    begin
      fill(wlen[i]);
      run(wid[i], 1'b0, RES_OK);
    end
    fill(100);
    run(8'd20, 1'b0, RES_UNKNOWN);
    fill(4);
    run(8'd59, 1'b0, RES_UNKNOWN);
    fill(3);
    run(8'd191, 1'b0, RES_UNKNOWN);
    run(8'd55, 1'b0, RES_OK);
    fill(4);
    sys_rdy = 1'b0;
    run(8'd180, 1'b0, RES_NOT_READY);
    sys_rdy = 1'b1;
    nvm = 1'b1;
    run(8'd180, 1'b0, RES_FLASH);
    nvm = 1'b0;
    fill(12);
    rng = 1'b1;
    run(8'd57, 1'b0, RES_RANGE);
    rng = 1'b0;
    // request: a state packet, boot mode, then a write-only id
    pl = '{8'h14, ID_BOOT, 8'hBE};
    rcrc = crc_of(pl);
    req_q.push_back(25'h0000014);
    exp_q.push_back({1'b1, ID_BOOT, BOOT_LEN, BOOT_LOADER});
    note_ack(8'hBE, rcrc, RES_UNKNOWN);
    u_host.send(ID_REQ, pl, rcrc);
    wait_idle("request");
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
